// ### hdl/mtp_pkg.sv
// constants, types and helper functions for the trigger and pulse block
package mtp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_COUNT  = 8'h04;
  localparam logic [7:0] REG_WIDTH  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_QUAL_LSB  = 2;
  localparam int CTRL_SPEED_LSB = 4;
  localparam int CTRL_FP_BIT    = 6;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int CTRL_OUTEN_BIT = 8;
  localparam int CTRL_POL_BIT   = 9;
  localparam int CTRL_WIDE_BIT  = 10;
  localparam int CMD_SINGLE_BIT = 0;

  localparam logic [10:0] COUNT_MIN     = 11'h001;
  localparam logic [10:0] COUNT_MAX     = 11'h7D0;
  localparam logic [10:0] COUNT_RST     = 11'h001;
  localparam logic [10:0] WIDTH_MIN     = 11'h001;
  localparam logic [10:0] FAST_DEF      = 11'h002;
  localparam logic [10:0] FAST_MAX      = 11'h007;
  localparam logic [10:0] FAST_WIDE_MAX = 11'h00B;
  localparam logic [10:0] MED_DEF       = 11'h00A;
  localparam logic [10:0] MED_MAX       = 11'h031;
  localparam logic [10:0] SLOW_DEF      = 11'h064;
  localparam logic [10:0] SLOW_FP_MAX   = 11'h63F;
  localparam logic [10:0] SLOW_MAX      = 11'h18F;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MTP_AUTO, MTP_SINGLE, MTP_EXT}                mtp_mode_t;
  typedef enum logic [1:0] {QUAL_RISE, QUAL_FALL, QUAL_LEVEL_HIGH, QUAL_LEVEL_LOW} mtp_qual_t;
  typedef enum logic [1:0] {SPD_FAST, SPD_MEDIUM, SPD_SLOW}               mtp_speed_t;

  localparam mtp_mode_t  MODE_RST  = MTP_AUTO;
  localparam mtp_qual_t  QUAL_RST  = QUAL_RISE;
  localparam mtp_speed_t SPEED_RST = SPD_SLOW;

  function automatic logic [10:0] width_max(mtp_speed_t sp, logic fp, logic wide);
    case (sp)
      SPD_FAST:   width_max = wide ? FAST_WIDE_MAX : FAST_MAX;
      SPD_MEDIUM: width_max = MED_MAX;
      default:    width_max = fp ? SLOW_FP_MAX : SLOW_MAX;
    endcase
  endfunction : width_max

  function automatic logic [10:0] width_def(mtp_speed_t sp);
    case (sp)
      SPD_FAST:   width_def = FAST_DEF;
      SPD_MEDIUM: width_def = MED_DEF;
      default:    width_def = SLOW_DEF;
    endcase
  endfunction : width_def
endpackage : mtp_pkg

// ### hdl/mtp_pulse_if.sv
// link from the trigger sequencer to the pulse generator
`timescale 1ns/100ps
interface mtp_pulse_if;
  logic        fire;
  logic [10:0] width_ms;
  logic        active_low;
  logic        active;
  modport src (output fire, output width_ms, output active_low, input active);
  modport gen (input fire, input width_ms, input active_low, output active);
endinterface : mtp_pulse_if

// ### hdl/mtp_trig_qual.sv
// external trigger qualifier: edge or level detection
`timescale 1ns/100ps
module mtp_trig_qual (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ext_in,
  input  mtp_pkg::mtp_qual_t     qual,
  output logic                   hit
);
  typedef struct packed {
    logic prev;
  } mtp_qual_st_t;

  mtp_qual_st_t s_q;
  mtp_qual_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.prev = ext_in;
    case (qual)
      mtp_pkg::QUAL_RISE:       hit = ext_in & ~s_q.prev;
      mtp_pkg::QUAL_FALL:       hit = ~ext_in & s_q.prev;
      mtp_pkg::QUAL_LEVEL_HIGH: hit = ext_in;
      mtp_pkg::QUAL_LEVEL_LOW:  hit = ~ext_in;
      default:                  hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q      <= '0;
      s_q.prev <= ext_in; // no false edge after reset
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rise_hit;
    (qual == mtp_pkg::QUAL_RISE) && hit |-> ext_in && !$past(ext_in);
  endproperty
  a_rise_hit: assert property (p_rise_hit) else $error("rise hit without rising edge");
endmodule : mtp_trig_qual

// ### hdl/mtp_pulse_gen.sv
// sample-done pulse generator with millisecond time base
`timescale 1ns/100ps
module mtp_pulse_gen #(
  parameter int MS_CYCLES = mtp_pkg::MS_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  rst,
  mtp_pulse_if.gen   pif,
  output logic       pulse_pin
);
  localparam int             PW       = $clog2(MS_CYCLES + 1);
  localparam logic [PW-1:0]  PRE_LAST = PW'(MS_CYCLES - 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [10:0]   rem;
    logic          pin;
  } mtp_pg_st_t;

  mtp_pg_st_t s_q;
  mtp_pg_st_t s_d;
  logic       tick;

  always_comb begin
    s_d  = s_q;
    tick = (s_q.pre == PRE_LAST);
    s_d.pre = tick ? '0 : s_q.pre + 1'b1;
    if (tick && s_q.rem != 11'h000) begin
      s_d.rem = s_q.rem - 11'h001;
    end
    if (pif.fire) begin
      s_d.rem = pif.width_ms;
      s_d.pre = '0;
    end
    s_d.pin = (s_d.rem != 11'h000) ^ pif.active_low;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pif.active = (s_q.rem != 11'h000);
  assign pulse_pin  = s_q.pin;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fire_load;
    pif.fire |=> pif.active && s_q.rem == $past(pif.width_ms) && s_q.pre == '0;
  endproperty
  a_fire_load: assert property (p_fire_load) else $error("pulse did not start");

  property p_pin_pol;
    ##1 pulse_pin == (pif.active ^ $past(pif.active_low));
  endproperty
  a_pin_pol: assert property (p_pin_pol) else $error("pulse polarity wrong");

  c_pulse: cover property (pif.fire ##1 pif.active);
endmodule : mtp_pulse_gen

// ### hdl/mtp_top.sv
// trigger sequencer with AXI4-Lite registers and sample-done pulse output
`timescale 1ns/100ps
module mtp_top #(
  parameter int AW        = 8,
  parameter int MS_CYCLES = mtp_pkg::MS_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          external_trigger_input,
  input  wire logic          sample_done,
  output logic               sample_start,
  output logic               sample_done_pulse_output
);
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} mtp_st_t;

  typedef struct packed {
    logic                aw_got;
    logic [AW-1:0]       awaddr;
    logic                w_got;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    mtp_pkg::mtp_mode_t  mode;
    mtp_pkg::mtp_qual_t  qual;
    mtp_pkg::mtp_speed_t speed;
    logic                fp;
    logic                force_auto;
    logic                out_en;
    logic                act_low;
    logic                wide;
    logic [10:0]         count;
    logic [10:0]         width;
    logic [10:0]         done_cnt;
    logic                single_pend;
    mtp_st_t             st;
    logic                start;
    logic                fire;
  } mtp_top_st_t;

  mtp_top_st_t s_q;
  mtp_top_st_t s_d;
  logic        hit;
  logic        pulse_active;
  mtp_pulse_if pif ();

  mtp_trig_qual u_qual (
    .clk    (clk),
    .rst    (rst),
    .ext_in (external_trigger_input),
    .qual   (s_q.qual),
    .hit    (hit)
  );

  mtp_pulse_gen #(.MS_CYCLES(MS_CYCLES)) u_pulse (
    .clk       (clk),
    .rst       (rst),
    .pif       (pif),
    .pulse_pin (sample_done_pulse_output)
  );

  assign pif.fire       = s_q.fire;
  assign pif.width_ms   = s_q.width;
  assign pif.active_low = s_q.act_low;
  assign pulse_active   = pif.active;

  function automatic logic [31:0] rd_word(logic [7:0] a, mtp_top_st_t s, logic act, logic ext);
    rd_word = 32'h0000_0000;
    case (a)
      mtp_pkg::REG_CTRL: begin
        rd_word[mtp_pkg::CTRL_MODE_LSB +: 2]  = s.mode;
        rd_word[mtp_pkg::CTRL_QUAL_LSB +: 2]  = s.qual;
        rd_word[mtp_pkg::CTRL_SPEED_LSB +: 2] = s.speed;
        rd_word[mtp_pkg::CTRL_FP_BIT]         = s.fp;
        rd_word[mtp_pkg::CTRL_FORCE_BIT]      = s.force_auto;
        rd_word[mtp_pkg::CTRL_OUTEN_BIT]      = s.out_en;
        rd_word[mtp_pkg::CTRL_POL_BIT]        = s.act_low;
        rd_word[mtp_pkg::CTRL_WIDE_BIT]       = s.wide;
      end
      mtp_pkg::REG_COUNT:  rd_word[10:0] = s.count;
      mtp_pkg::REG_WIDTH:  rd_word[10:0] = s.width;
      mtp_pkg::REG_STATUS: rd_word = {17'h0_0000, s.done_cnt, s.single_pend, ext, act,
                                      (s.st == ST_WAIT)};
      default:             rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  function automatic logic mapped(logic [7:0] a);
    mapped = (a == mtp_pkg::REG_CTRL) || (a == mtp_pkg::REG_COUNT) ||
             (a == mtp_pkg::REG_WIDTH) || (a == mtp_pkg::REG_CMD) ||
             (a == mtp_pkg::REG_STATUS);
  endfunction : mapped

  always_comb begin
    logic [7:0]          wa;
    logic [31:0]         mask;
    logic [31:0]         mw;
    logic [10:0]         wmax;
    mtp_pkg::mtp_speed_t nsp;
    logic                go;
    logic [10:0]         ncnt;
    wa   = 8'(s_q.awaddr);
    mask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    mw   = (rd_word(wa, s_q, pulse_active, external_trigger_input) & ~mask) |
           (s_q.wdata & mask);
    wmax = mtp_pkg::width_max(s_q.speed, s_q.fp, s_q.wide);
    nsp  = mtp_pkg::SPD_SLOW;
    go   = 1'b0;
    ncnt = s_q.done_cnt + 11'h001;
    s_d       = s_q;
    s_d.start = 1'b0;
    s_d.fire  = 1'b0;
    // trigger sequencing
    case (s_q.st)
      ST_IDLE: begin
        case (s_q.mode)
          mtp_pkg::MTP_AUTO:   go = 1'b1;
          mtp_pkg::MTP_SINGLE: go = s_q.single_pend;
          mtp_pkg::MTP_EXT:    go = hit;
          default:             go = 1'b0;
        endcase
        if (s_q.mode != mtp_pkg::MTP_SINGLE) begin
          s_d.single_pend = 1'b0;
        end
        if (go) begin
          s_d.st          = ST_WAIT;
          s_d.start       = 1'b1;
          s_d.done_cnt    = 11'h000;
          s_d.single_pend = 1'b0;
        end
      end
      ST_WAIT: begin
        if (sample_done) begin
          s_d.done_cnt = ncnt;
          s_d.fire     = s_q.out_en && (s_q.mode != mtp_pkg::MTP_AUTO);
          if (ncnt >= s_q.count) begin
            s_d.st = ST_IDLE;
          end else begin
            s_d.start = 1'b1;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = mapped(wa) ? mtp_pkg::RESP_OKAY : mtp_pkg::RESP_SLVERR;
      case (wa)
        mtp_pkg::REG_CTRL: begin
          nsp            = (mw[mtp_pkg::CTRL_SPEED_LSB +: 2] == 2'h3) ? mtp_pkg::SPD_SLOW :
                           mtp_pkg::mtp_speed_t'(mw[mtp_pkg::CTRL_SPEED_LSB +: 2]);
          s_d.force_auto = mw[mtp_pkg::CTRL_FORCE_BIT];
          s_d.mode       = (mw[mtp_pkg::CTRL_FORCE_BIT] ||
                            mw[mtp_pkg::CTRL_MODE_LSB +: 2] == 2'h3) ? mtp_pkg::MTP_AUTO :
                           mtp_pkg::mtp_mode_t'(mw[mtp_pkg::CTRL_MODE_LSB +: 2]);
          s_d.qual       = mtp_pkg::mtp_qual_t'(mw[mtp_pkg::CTRL_QUAL_LSB +: 2]);
          s_d.speed      = nsp;
          s_d.fp         = mw[mtp_pkg::CTRL_FP_BIT];
          s_d.out_en     = mw[mtp_pkg::CTRL_OUTEN_BIT];
          s_d.act_low    = mw[mtp_pkg::CTRL_POL_BIT];
          s_d.wide       = mw[mtp_pkg::CTRL_WIDE_BIT];
          wmax = mtp_pkg::width_max(nsp, mw[mtp_pkg::CTRL_FP_BIT], mw[mtp_pkg::CTRL_WIDE_BIT]);
          if (nsp != s_q.speed) begin
            s_d.width = mtp_pkg::width_def(nsp);
          end else if (s_q.width > wmax) begin
            s_d.width = wmax;
          end
        end
        mtp_pkg::REG_COUNT: begin
          if (mw[31:11] != 21'h000000 || mw[10:0] > mtp_pkg::COUNT_MAX) begin
            s_d.count = mtp_pkg::COUNT_MAX;
          end else if (mw[10:0] < mtp_pkg::COUNT_MIN) begin
            s_d.count = mtp_pkg::COUNT_MIN;
          end else begin
            s_d.count = mw[10:0];
          end
        end
        mtp_pkg::REG_WIDTH: begin
          if (mw[31:11] != 21'h000000 || mw[10:0] > wmax) begin
            s_d.width = wmax;
          end else if (mw[10:0] < mtp_pkg::WIDTH_MIN) begin
            s_d.width = mtp_pkg::WIDTH_MIN;
          end else begin
            s_d.width = mw[10:0];
          end
        end
        mtp_pkg::REG_CMD: begin
          if (s_q.wstrb[0] && s_q.wdata[mtp_pkg::CMD_SINGLE_BIT] &&
              s_q.mode == mtp_pkg::MTP_SINGLE) begin
            s_d.single_pend = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word(8'(s_axi_araddr), s_q, pulse_active, external_trigger_input);
      s_d.rresp  = mapped(8'(s_axi_araddr)) ? mtp_pkg::RESP_OKAY : mtp_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q       <= '0;
      s_q.mode  <= mtp_pkg::MODE_RST;
      s_q.qual  <= mtp_pkg::QUAL_RST;
      s_q.speed <= mtp_pkg::SPEED_RST;
      s_q.count <= mtp_pkg::COUNT_RST;
      s_q.width <= mtp_pkg::SLOW_DEF;
      s_q.st    <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign sample_start  = s_q.start;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_count_range;
    s_q.count >= mtp_pkg::COUNT_MIN && s_q.count <= mtp_pkg::COUNT_MAX;
  endproperty
  a_count_range: assert property (p_count_range) else $error("sample count out of range");

  property p_burst_len;
    s_q.st == ST_WAIT && sample_done && s_q.done_cnt + 11'h001 < s_q.count |=> sample_start;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst ended early");

  property p_single_start;
    s_q.st == ST_IDLE && s_q.mode == mtp_pkg::MTP_SINGLE && s_q.single_pend
      |=> sample_start && !s_q.single_pend [*1];
  endproperty
  a_single_start: assert property (p_single_start) else $error("single request not served");

  property p_no_fire_auto;
    s_q.mode == mtp_pkg::MTP_AUTO || !s_q.out_en |=> !s_q.fire;
  endproperty
  a_no_fire_auto: assert property (p_no_fire_auto) else $error("pulse fired while not allowed");

  property p_fast_w;
    s_q.speed == mtp_pkg::SPD_FAST |-> s_q.width >= 11'h001 && s_q.width <= 11'h00B;
  endproperty
  a_fast_w: assert property (p_fast_w) else $error("fast width out of range");

  property p_med_w;
    s_q.speed == mtp_pkg::SPD_MEDIUM |-> s_q.width >= 11'h001 && s_q.width <= 11'h031;
  endproperty
  a_med_w: assert property (p_med_w) else $error("medium width out of range");

  property p_slow_w;
    s_q.speed == mtp_pkg::SPD_SLOW && !s_q.fp |-> s_q.width >= 11'h001 && s_q.width <= 11'h18F;
  endproperty
  a_slow_w: assert property (p_slow_w) else $error("slow width out of range");

  property p_qual_rst;
    $past(rst) |-> s_q.qual == mtp_pkg::QUAL_RISE && !s_q.out_en;
  endproperty
  a_qual_rst: assert property (p_qual_rst) else $error("reset defaults wrong");

  property p_ext_start;
    s_q.st == ST_IDLE && s_q.mode == mtp_pkg::MTP_EXT && hit |=> sample_start ##1 s_q.st == ST_WAIT;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external trigger missed");

  property p_level_cont;
    s_q.mode == mtp_pkg::MTP_EXT && s_q.qual == mtp_pkg::QUAL_LEVEL_HIGH &&
      external_trigger_input && s_q.st == ST_IDLE |=> sample_start;
  endproperty
  a_level_cont: assert property (p_level_cont) else $error("level trigger not continuous");

  property p_forced;
    s_q.force_auto |-> s_q.mode == mtp_pkg::MTP_AUTO;
  endproperty
  a_forced: assert property (p_forced) else $error("forced auto not kept");

  c_single: cover property (s_q.mode == mtp_pkg::MTP_SINGLE && sample_start);
  c_ext:    cover property (s_q.mode == mtp_pkg::MTP_EXT && sample_start);
  c_fire:   cover property (s_q.fire ##1 pulse_active);
  c_auto:   cover property (s_q.mode == mtp_pkg::MTP_AUTO && sample_start);
endmodule : mtp_top

// ### verif/mtp_partner.sv
// partner model: sampling engine, trigger source and pulse meter
`timescale 1ns/100ps
module mtp_partner #(
  parameter int DELAY = 3
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sample_start,
  input  wire logic pulse_in,
  input  wire logic active_low,
  input  wire logic ext_cmd,
  output logic      sample_done,
  output logic      ext_out,
  output int        last_width
);
  int wait_q;
  int run_q;
  // trigger level as commanded; spacing kept long by the bench
  assign ext_out = ext_cmd;
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q      <= 0;
      run_q       <= 0;
      last_width  <= 0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= (wait_q == 1);
      if (sample_start) wait_q <= DELAY;
      else if (wait_q != 0) wait_q <= wait_q - 1;
      // active cycles of the sample-done pulse
      if (pulse_in ^ active_low) run_q <= run_q + 1;
      else if (run_q != 0) begin
        last_width <= run_q;
        run_q      <= 0;
      end
    end
  end
endmodule : mtp_partner

// ### verif/test_mtp_top.sv
// self-checking bench for the trigger and pulse block
`timescale 1ns/100ps
module test_mtp_top;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, ext_cmd, pol;
  logic        awready, wready, bvalid, arready, rvalid, sdone, sstart, pin, ext;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd, rdata;
  logic [1:0]  resp, bresp, rresp;
  int          bad_count, checked, starts, cycles, wseen, s0;
  logic [31:0] wctl [5] = '{32'h000, 32'h410, 32'h400, 32'h060, 32'h020};
  logic [31:0] wdef [5] = '{32'h002, 32'h00A, 32'h002, 32'h064, 32'h18F};
  logic [31:0] wmax [5] = '{32'h007, 32'h031, 32'h00B, 32'h63F, 32'h18F};

  mtp_top #(.AW(8), .MS_CYCLES(10)) i_dut (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_trigger_input(ext), .sample_done(sdone), .sample_start(sstart),
    .sample_done_pulse_output(pin));
  mtp_partner #(.DELAY(3)) i_partner (.clk(clk), .rst(rst), .sample_start(sstart),
    .pulse_in(pin), .active_low(pol), .ext_cmd(ext_cmd), .sample_done(sdone),
    .ext_out(ext), .last_width(wseen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sstart === 1'b1) starts <= starts + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid;
      resp  = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end while (!b_hs);
    bready <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic ar_hs, r_hs;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid;
      rd    = rdata;
      resp  = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
    end while (!r_hs);
    rready <= 1'b0;
    chk(nm, rd, exp);
  endtask : rchk

  task automatic t_reset();
    rchk(8'h00, 32'h020, "ctrl");
    chk("ctrl resp", {30'h0, resp}, {30'h0, mtp_pkg::RESP_OKAY});
    rchk(8'h04, 32'h001, "count");
    rchk(8'h08, 32'h064, "width");
    rchk(8'h14, 32'h000, "unmapped read");
    chk("unmapped resp", {30'h0, resp}, {30'h0, mtp_pkg::RESP_SLVERR});
    wr(8'h14, 32'h0);
    chk("unmapped wr resp", {30'h0, resp}, {30'h0, mtp_pkg::RESP_SLVERR});
    $display("reset test done");
  endtask : t_reset

  task automatic t_width();
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, wctl[i]);
      rchk(8'h08, wdef[i], "width default");
      wr(8'h08, 32'h7FF);
      chk("width wr resp", {30'h0, resp}, {30'h0, mtp_pkg::RESP_OKAY});
      rchk(8'h08, wmax[i], "width max");
    end
    wr(8'h08, 32'h0);
    rchk(8'h08, 32'h001, "width min");
    wr(8'h04, 32'h0);
    rchk(8'h04, 32'h001, "count min");
    wr(8'h04, 32'hFFF);
    rchk(8'h04, 32'h7D0, "count max");
    $display("range test done");
  endtask : t_width

  task automatic t_single();
    wr(8'h00, 32'h001);
    wr(8'h04, 32'h001);
    wt(30);
    s0 = starts;
    wr(8'h0C, 32'h1);
    wt(40);
    chk("single starts", starts - s0, 1);
    chk("pulse while off", wseen, 0);
    wr(8'h00, 32'h101);
    wr(8'h0C, 32'h1);
    wt(60);
    chk("pulse width", wseen, 20);
    wr(8'h00, 32'h301);
    pol <= 1'b1;
    wt(2);
    chk("idle level", {31'h0, pin}, 1);
    wr(8'h0C, 32'h1);
    wt(60);
    chk("low pulse width", wseen, 20);
    wr(8'h04, 32'h003);
    s0 = starts;
    wr(8'h0C, 32'h1);
    wt(80);
    chk("burst starts", starts - s0, 3);
    rchk(8'h10, 32'h030, "burst status");
    $display("single test done");
  endtask : t_single

  task automatic t_ext();
    pol <= 1'b0;
    wr(8'h04, 32'h001);
    for (int q = 0; q < 4; q++) begin
      ext_cmd <= q[0];
      wr(8'h00, 32'h102 | 32'(q << 2));
      wt(30);
      s0 = starts;
      wt(30);
      chk("ext idle", starts - s0, 0);
      ext_cmd <= !q[0];
      wt(60);
      if (q < 2) begin
        chk("ext edge", starts - s0, 1);
        chk("ext pulse", wseen, 20);
      end else chk("ext level", 32'(starts - s0 > 3), 1);
    end
    $display("external test done");
  endtask : t_ext

  task automatic t_force();
    wr(8'h00, 32'h081);
    rchk(8'h00, 32'h080, "forced single");
    wr(8'h00, 32'h082);
    rchk(8'h00, 32'h080, "forced ext");
    wr(8'h00, 32'h033);
    rchk(8'h00, 32'h020, "code 3 mapping");
    rchk(8'h08, 32'h064, "slow reload");
    $display("forced auto test done");
  endtask : t_force

  task automatic t_rerun();
    wr(8'h04, 32'h005);
    wr(8'h08, 32'h005);
    rst <= 1'b1;
    wt(5);
    rst <= 1'b0;
    rchk(8'h04, 32'h001, "count after reset");
    rchk(8'h08, 32'h064, "width after reset");
    rchk(8'h00, 32'h020, "ctrl after reset");
    $display("mid-run reset test done");
  endtask : t_rerun

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, ext_cmd, pol} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    {bad_count, checked, starts, cycles} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_width();
    t_single();
    t_ext();
    t_force();
    t_rerun();
    finish_test();
  end
endmodule : test_mtp_top
